/* hw/kwdt_top.sv */
// Keyed watchdog timer: 19-bit timer, key and reload registers, power-control bits.
// Assumes one clock, synchronous writes from the core, reset output fed back to rstn.
// Functional notes
// R01: Timer is 11-bit prescaler feeding an 8-bit loadable counter, 19 bits total.
// R02: Timer advances once per 6-clock machine cycle, in its second state.
// R03: Overflow of the 8-bit counter resets the microcontroller.
// R04: Interval is (256 minus load) times 2048 machine cycles.
// R05: After any reset the load/counter register holds zero.
// R06: Reload writes are accepted only while load-enable is set.
// R07: First setting of load-enable starts the watchdog.
// R08: Writing 55H to the key, or hardware reset, disables the watchdog.
// R09: While key holds 55H, power-down bit cannot be set.
// R10: Any key other than 55H enables or re-enables the watchdog.
// R11: Key register at FE, reload register at FF, both write-only.
// R12: Power-control at 87H, load-enable is bit mask 10H.
// R13: Software must reload before expiry to avoid reset.
// R14: Accepted reload sets counter to value and clears prescaler.
// R15: Watchdog reset returns block to disabled, cleared state.
`default_nettype none

module kwdt_top (
  // Clock, reset, enable
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  clkEn,
  // Core write port
  input  wire kwdt_pkg::kwdt_sfr_wr_t sfrWr,
  // Status and reset out
  output var  kwdt_pkg::kwdt_status_t status,
  output logic                       wdtReset
);

  // Decode
  wire wrKey    = sfrWr.valid && (sfrWr.addr == kwdt_pkg::KWDT_ADDR_KEY);    // R11
  wire wrReload = sfrWr.valid && (sfrWr.addr == kwdt_pkg::KWDT_ADDR_RELOAD); // R11
  wire wrPwr    = sfrWr.valid && (sfrWr.addr == kwdt_pkg::KWDT_ADDR_PWRCTL); // R12

  logic [7:0]                      key_r;
  logic                            loadEn_r;
  logic                            powerDown_r;
  logic                            started_r;
  logic [2:0]                      phase_r;
  logic [kwdt_pkg::KWDT_PRESC_W-1:0] presc_r;
  logic [kwdt_pkg::KWDT_COUNT_W-1:0] count_r;

  wire keyDisabled = (key_r == kwdt_pkg::KWDT_KEY_DISABLE);
  wire newLoadEn   = sfrWr.data[kwdt_pkg::KWDT_LOAD_EN_POS];
  wire newPd       = sfrWr.data[kwdt_pkg::KWDT_POWER_DOWN_POS];
  wire running     = started_r && !keyDisabled;
  wire tick        = running && (phase_r == kwdt_pkg::KWDT_PHASE_TICK);              // R02
  wire prescWrap   = tick && (&presc_r);                                             // R01
  wire overflow    = prescWrap && (&count_r);                                        // R03 R04
  wire reloadOk    = wrReload && loadEn_r;                                           // R06
  wire powerUp     = wrKey && (sfrWr.data != kwdt_pkg::KWDT_KEY_DISABLE);            // R10

  wire [2:0] phaseNxt = (phase_r == kwdt_pkg::KWDT_PHASE_LAST) ? 3'h0 : phase_r + 3'h1;

  // Reset of the core is requested by overflow and fed back via rstn
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      key_r       <= kwdt_pkg::KWDT_KEY_RESET;      // R08 R15
      loadEn_r    <= 1'b0;
      powerDown_r <= 1'b0;
      started_r   <= 1'b0;
      phase_r     <= 3'h0;
      presc_r     <= '0;
      count_r     <= kwdt_pkg::KWDT_RELOAD_RESET;   // R05
      wdtReset    <= 1'b0;
    end else if (clkEn) begin
      phase_r  <= phaseNxt;
      // Reload landing in the overflow cycle wins, no reset then
      wdtReset <= overflow && !reloadOk;            // R03 R15
      if (wrKey) begin
        key_r <= sfrWr.data;                        // R08 R10
      end
      if (wrPwr) begin
        loadEn_r    <= newLoadEn;                   // R12
        powerDown_r <= newPd && !keyDisabled;       // R09
        if (newLoadEn) begin
          started_r <= 1'b1;                        // R07
        end
      end
      if (reloadOk) begin
        count_r <= sfrWr.data;                      // R14
        presc_r <= '0;                              // R14
      end else if (tick) begin
        presc_r <= presc_r + 11'h001;               // R01
        if (prescWrap) begin
          count_r <= count_r + 8'h01;               // R01
        end
      end
    end
  end

  // Checker helper: ticks since the last accepted reload
  // Counts only real ticks, so key-off pauses do not skew it
  logic [19:0] tickCnt_r;
  logic [7:0]  loadVal_r;
  logic        loadSeen_r;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tickCnt_r  <= '0;
      loadVal_r  <= '0;
      loadSeen_r <= 1'b0;
    end else if (clkEn) begin
      if (reloadOk) begin
        tickCnt_r  <= '0;
        loadVal_r  <= sfrWr.data;
        loadSeen_r <= 1'b1;
      end else if (tick) begin
        tickCnt_r <= tickCnt_r + 20'h00001;
      end
    end
  end

  // Ticks before the overflow tick: (256 - load) * 2048 - 1
  wire [19:0] ticksDue = {(9'h100 - {1'b0, loadVal_r}), 11'h000} - 20'h00001; // R04

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status <= '0;
    end else if (clkEn) begin
      status.running    <= running;
      status.loadEnable <= loadEn_r;
      status.powerDown  <= powerDown_r;
      status.count      <= count_r;
    end
  end

  // Assertions
  property p_reload_load;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && reloadOk |=> count_r == $past(sfrWr.data) && presc_r == '0;
  endproperty
  a_reload_load: assert property (p_reload_load) else $error("reload not taken"); // R14

  property p_reload_block;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && wrReload && !loadEn_r && !tick |=> $stable(count_r);
  endproperty
  a_reload_block: assert property (p_reload_block) else $error("locked reload taken"); // R06

  property p_tick_phase;
    @(posedge sys_clk) disable iff (!rstn)
      tick |-> phase_r == 3'h1;
  endproperty
  a_tick_phase: assert property (p_tick_phase) else $error("tick off phase"); // R02

  property p_phase_wrap;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && phase_r == 3'h5 |=> phase_r == 3'h0;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("cycle not 6 clocks"); // R02

  property p_overflow_reset;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && overflow && !reloadOk |=> wdtReset;
  endproperty
  a_overflow_reset: assert property (p_overflow_reset) else $error("no reset on overflow"); // R03

  property p_key_stops;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && wrKey && sfrWr.data == kwdt_pkg::KWDT_KEY_DISABLE |=> !running;
  endproperty
  a_key_stops: assert property (p_key_stops) else $error("key did not disable"); // R08

  property p_pd_inhibit;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && wrPwr && keyDisabled |=> !powerDown_r;
  endproperty
  a_pd_inhibit: assert property (p_pd_inhibit) else $error("power-down set while keyed"); // R09

  property p_first_start;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && wrPwr && newLoadEn |=> started_r;
  endproperty
  a_first_start: assert property (p_first_start) else $error("load-enable did not start"); // R07

  property p_key_enable;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && powerUp && started_r |=> running;
  endproperty
  a_key_enable: assert property (p_key_enable) else $error("key did not re-enable"); // R10

  property p_reset_zero;
    @(posedge sys_clk) !rstn |=> count_r == 8'h00 && !started_r;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset state wrong"); // R05 R15

  property p_interval;
    @(posedge sys_clk) disable iff (!rstn)
      overflow && loadSeen_r |-> tickCnt_r == ticksDue;
  endproperty
  a_interval: assert property (p_interval) else $error("interval length wrong"); // R04

  property p_wrap_point;
    @(posedge sys_clk) disable iff (!rstn)
      overflow |-> count_r == 8'hFF && presc_r == 11'h7FF;
  endproperty
  a_wrap_point: assert property (p_wrap_point) else $error("overflow not at wrap"); // R01 R04

  property p_presc_step;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && tick && !reloadOk |=> presc_r == $past(presc_r) + 11'h001;
  endproperty
  a_presc_step: assert property (p_presc_step) else $error("prescaler did not step"); // R01

  property p_count_step;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && prescWrap && !reloadOk |=> count_r == $past(count_r) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step"); // R01

  property p_count_hold;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && !prescWrap && !reloadOk |=> $stable(count_r);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved early"); // R01

  property p_presc_idle;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && !tick && !reloadOk |=> $stable(presc_r);
  endproperty
  a_presc_idle: assert property (p_presc_idle) else $error("prescaler off tick"); // R02

  property p_stopped_hold;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && !running && !reloadOk |=> $stable(presc_r) && $stable(count_r);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("stopped timer moved"); // R08

  property p_reset_pulse;
    @(posedge sys_clk) wdtReset |=> !wdtReset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long"); // R03

  property p_no_spurious;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && !(overflow && !reloadOk) |=> !wdtReset;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("reset without overflow"); // R03

  property p_key_store;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && wrKey |=> key_r == $past(sfrWr.data);
  endproperty
  a_key_store: assert property (p_key_store) else $error("key not stored"); // R10

  property p_loaden_store;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && wrPwr |=> loadEn_r == $past(newLoadEn);
  endproperty
  a_loaden_store: assert property (p_loaden_store) else $error("load-enable not stored"); // R12

  property p_pd_follow;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && wrPwr && !keyDisabled |=> powerDown_r == $past(newPd);
  endproperty
  a_pd_follow: assert property (p_pd_follow) else $error("power-down not stored"); // R09

  property p_started_sticky;
    @(posedge sys_clk) disable iff (!rstn)
      started_r |=> started_r;
  endproperty
  a_started_sticky: assert property (p_started_sticky) else $error("start lost"); // R07

  property p_start_only_le;
    @(posedge sys_clk) disable iff (!rstn)
      !started_r && !(clkEn && wrPwr && newLoadEn) |=> !started_r;
  endproperty
  a_start_only_le: assert property (p_start_only_le) else $error("started without enable"); // R07

  property p_other_addr;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn && sfrWr.valid && !wrKey && !wrReload && !wrPwr
      |=> $stable(key_r) && $stable(loadEn_r) && $stable(powerDown_r);
  endproperty
  a_other_addr: assert property (p_other_addr) else $error("foreign address taken"); // R11

  property p_clken_freeze;
    @(posedge sys_clk) disable iff (!rstn)
      !clkEn |=> $stable(count_r) && $stable(presc_r) && $stable(phase_r)
      && $stable(key_r) && $stable(loadEn_r) && $stable(wdtReset);
  endproperty
  a_clken_freeze: assert property (p_clken_freeze) else $error("state moved while frozen"); // R01

  property p_status_mirror;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn |=> status.count == $past(count_r) && status.running == $past(running);
  endproperty
  a_status_mirror: assert property (p_status_mirror) else $error("status out of step"); // R05

  property p_reset_key;
    @(posedge sys_clk) !rstn |=> key_r == kwdt_pkg::KWDT_KEY_RESET && !wdtReset && status == '0;
  endproperty
  a_reset_key: assert property (p_reset_key) else $error("reset left block enabled"); // R08 R15

  c_pdblock:  cover property (@(posedge sys_clk) wrPwr && newPd && keyDisabled);
  c_reenable: cover property (@(posedge sys_clk) powerUp && started_r);
  c_reload:   cover property (@(posedge sys_clk) reloadOk);
  c_overflow: cover property (@(posedge sys_clk) overflow);
  c_keyoff:   cover property (@(posedge sys_clk) wrKey && sfrWr.data == 8'h55 && started_r);

endmodule : kwdt_top

`default_nettype wire

/* hw/kwdt_pkg.sv */
// Package for the keyed watchdog timer: special function addresses, field
// positions, reset values, timing counts and carrier structs.
// Assumes a core that issues one-cycle writes on an 8-bit register port.
`default_nettype none

package kwdt_pkg;

  // Register addresses
  localparam logic [7:0] KWDT_ADDR_KEY    = 8'hFE;
  localparam logic [7:0] KWDT_ADDR_RELOAD = 8'hFF;
  localparam logic [7:0] KWDT_ADDR_PWRCTL = 8'h87;

  // Field positions in the power-control register
  localparam int KWDT_LOAD_EN_POS    = 4;
  localparam int KWDT_POWER_DOWN_POS = 1;

  // Reset values and key code
  localparam logic [7:0] KWDT_KEY_RESET    = 8'h55;
  localparam logic [7:0] KWDT_KEY_DISABLE  = 8'h55;
  localparam logic [7:0] KWDT_RELOAD_RESET = 8'h00;
  localparam logic [7:0] KWDT_PWRCTL_RESET = 8'h00;

  // Counter geometry
  localparam int KWDT_PRESC_W = 11;
  localparam int KWDT_COUNT_W = 8;

  // Machine cycle: 6 clocks, counter steps in state 2 (phase index 1)
  localparam int         KWDT_CYCLE_CLKS = 6;
  localparam logic [2:0] KWDT_PHASE_LAST = 3'h5;
  localparam logic [2:0] KWDT_PHASE_TICK = 3'h1;

  // Write request from the core
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } kwdt_sfr_wr_t;

  // Watchdog state seen by the core
  typedef struct packed {
    logic       running;
    logic       loadEnable;
    logic       powerDown;
    logic [7:0] count;
  } kwdt_status_t;

endpackage : kwdt_pkg

`default_nettype wire

/* dv/kwdt_core_model.sv */
// Core model: issues one-cycle special function register writes.
// Assumes writes launch 1 ns after a rising clock edge.
`default_nettype none

module kwdt_core_model (
  // Clock
  input  wire logic                   sys_clk,
  // Write port
  output var  kwdt_pkg::kwdt_sfr_wr_t sfrWr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial sfrWr = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    sfrWr = '{valid: 1'b1, addr: a, data: d};
    @(posedge sys_clk);
    #1;
    // Released bus shows inverted values, not a held copy
    sfrWr = '{valid: 1'b0, addr: ~a, data: ~d};
  endtask : wr

  // Service routine: enable loading, then reload
  task automatic reload(input logic [7:0] v);
    wr(kwdt_pkg::KWDT_ADDR_PWRCTL, 8'h10);
    wr(kwdt_pkg::KWDT_ADDR_RELOAD, v);
  endtask : reload
endmodule : kwdt_core_model

`default_nettype wire

/* dv/tb_top.sv */
// Bench for the keyed watchdog: table of writes, then overflow timing.
// Assumes the core model drives writes and wdtReset feeds back into rstn.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   sys_clk      = 1'b0;
  logic                   hwRstn       = 1'b0;
  logic                   clkEn        = 1'b1;
  wire logic              rstn;
  kwdt_pkg::kwdt_sfr_wr_t sfrWr;
  kwdt_pkg::kwdt_status_t status;
  logic                   wdtReset;
  int                     errors       = 0;
  int                     total_checks = 0;
  int                     n;
  // Address, data, expected {running, loadEnable, powerDown, count}
  logic [26:0]            rows [10]    = '{
    {8'hFF, 8'h12, 3'h0, 8'h00}, {8'h87, 8'h12, 3'h2, 8'h00},
    {8'hFE, 8'hAA, 3'h6, 8'h00}, {8'h87, 8'h12, 3'h7, 8'h00},
    {8'h87, 8'h10, 3'h6, 8'h00}, {8'hFF, 8'h34, 3'h6, 8'h34},
    {8'h80, 8'h77, 3'h6, 8'h34}, {8'hFE, 8'h55, 3'h2, 8'h34},
    {8'h87, 8'h12, 3'h2, 8'h34}, {8'hFE, 8'h01, 3'h6, 8'h34}};

  // Watchdog reset folds into the synchronous reset
  assign rstn = hwRstn & ~wdtReset;

  initial forever #10 sys_clk = ~sys_clk;

  kwdt_core_model kwdt_core_model_i (.sys_clk(sys_clk), .sfrWr(sfrWr));
  kwdt_top kwdt_top_i (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .sfrWr(sfrWr),
    .status(status), .wdtReset(wdtReset));

  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    hwRstn = 1'b1;
    chk("reset status", 11'h000, status);
    foreach (rows[i]) begin
      kwdt_core_model_i.wr(rows[i][26:19], rows[i][18:11]);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("status", rows[i][10:0], status);
    end
    // Mid-interval reload must restart the full interval
    kwdt_core_model_i.reload(8'hFF);
    repeat (6000) @(posedge sys_clk);
    kwdt_core_model_i.reload(8'hFF);
    n = 0;
    while (wdtReset !== 1'b1 && n < 13000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    // Phase of first tick is unknown, hence the small window
    chk("overflow window", 11'h001, {10'h0, n >= 12282 && n <= 12287});
    @(posedge sys_clk);
    #1;
    chk("reset pulse", 11'h000, {10'h0, wdtReset});
    repeat (2) @(posedge sys_clk);
    #1;
    chk("status after overflow", 11'h000, status);
    // Enable low must freeze everything, writes included
    clkEn = 1'b0;
    kwdt_core_model_i.wr(kwdt_pkg::KWDT_ADDR_KEY, 8'hAA);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("frozen status", 11'h000, status);
    clkEn = 1'b1;
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
